// ===== rtl/irq_flags_pkg.sv
// constants for the peripheral flag, enable and reset-cause registers
// assumes an 8-bit register port addressed by file address
package irq_flags_pkg;
  // register offsets
  localparam logic [7:0] flags1_off = 8'h0c;
  localparam logic [7:0] flags2_off = 8'h0d;
  localparam logic [7:0] enable2_off = 8'h8d;
  localparam logic [7:0] reset_cause_off = 8'h8e;
  // field positions
  localparam int timer1_overflow_bit = 0;
  localparam int timer2_match_bit = 1;
  localparam int conversion_done_bit = 6;
  localparam int parallel_port_bit = 7;
  localparam int capcmp2_bit = 0;
  localparam int brownout_bit = 0;
  localparam int power_on_bit = 1;
  // reset values
  localparam logic [7:0] flags2_reset = 8'h00;
  localparam logic [7:0] enable2_reset = 8'h00;
  localparam logic [1:0] flags1_hi_reset = 2'h0;
  // capture/compare unit modes
  typedef enum logic [1:0] {
    capcmp_off,
    capcmp_capture,
    capcmp_compare,
    capcmp_pwm
  } capcmp_mode_e;
endpackage : irq_flags_pkg

// ===== rtl/sticky_flag.sv
// one hardware-set, software-written flag bit
// assumes set and write strobes synchronous to clk_in
`timescale 1ns/1ns
module sticky_flag (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic set_in,
  input wire logic write_in,
  input wire logic write_value_in,
  // state
  output logic flag_out
);
  typedef struct packed {
    logic flag;
  } state_s;

  state_s state_reg;
  state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (write_in) begin
      state_next.flag = write_value_in;
    end
    // set beats a same-cycle clear
    if (set_in) begin
      state_next.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag_out = state_reg.flag;
endmodule : sticky_flag

// ===== rtl/peripheral_irq_flags_reset_cause.sv
// peripheral flag bits, second enable register and reset-cause status
// assumes timer and capture/compare inputs synchronous to clk_in
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module peripheral_irq_flags_reset_cause #(
  parameter bit has_parallel_port = 1'b1,
  parameter bit has_converter = 1'b1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // reset cause, held by the reset logic until the first edge after reset release
  input wire logic power_on_reset_in,
  input wire logic brownout_reset_in,
  input wire logic brownout_detect_enable_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  // timer events
  input wire logic [7:0] timer2_count_in,
  input wire logic [7:0] timer2_period_in,
  input wire logic timer2_tick_in,
  input wire logic [15:0] timer1_count_in,
  input wire logic timer1_tick_in,
  // second capture/compare unit
  input wire irq_flags_pkg::capcmp_mode_e capcmp2_mode_in,
  input wire logic capcmp2_capture_in,
  input wire logic capcmp2_match_in,
  // flag outputs
  output logic [7:0] flags1_hi_out,
  output logic capcmp2_request_out
);
  import irq_flags_pkg::*;

  typedef struct packed {
    logic capcmp2_enable;
    logic power_on_n;
    logic brownout_n;
    logic cause_pending;
    logic [7:0] rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic timer2_match_flag;
  logic timer1_overflow_flag;
  logic capcmp2_irq_flag;
  logic timer2_set;
  logic timer1_set;
  logic capcmp2_set;

  function automatic logic write_hit(input logic [7:0] off);
    write_hit = write_in && (addr_in == off);
  endfunction : write_hit

  // ------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------
  assign timer2_set = timer2_tick_in && (timer2_count_in == timer2_period_in);
  assign timer1_set = timer1_tick_in && (timer1_count_in == 16'hffff);
  always_comb begin
    capcmp2_set = 1'b0;
    case (capcmp2_mode_in)
      capcmp_capture: capcmp2_set = capcmp2_capture_in;
      capcmp_compare: capcmp2_set = capcmp2_match_in;
      default: capcmp2_set = 1'b0;
    endcase
  end

  sticky_flag timer2_flag_i (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .set_in(timer2_set),
    .write_in(write_hit(flags1_off)),
    .write_value_in(wdata_in[timer2_match_bit]),
    .flag_out(timer2_match_flag)
  );

  sticky_flag timer1_flag_i (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .set_in(timer1_set),
    .write_in(write_hit(flags1_off)),
    .write_value_in(wdata_in[timer1_overflow_bit]),
    .flag_out(timer1_overflow_flag)
  );

  sticky_flag capcmp2_flag_i (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .set_in(capcmp2_set),
    .write_in(write_hit(flags2_off)),
    .write_value_in(wdata_in[capcmp2_bit]),
    .flag_out(capcmp2_irq_flag)
  );

  // ------------------------------------------------------------
  // registers and read mux
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 8'h00;
    // capture the cause on the first edge after reset release
    if (state_reg.cause_pending) begin
      state_next.cause_pending = 1'b0;
      if (power_on_reset_in) begin
        state_next.power_on_n = 1'b0;
      end
      if (brownout_reset_in && brownout_detect_enable_in) begin
        state_next.brownout_n = 1'b0;
      end
    end
    if (write_hit(enable2_off)) begin
      state_next.capcmp2_enable = wdata_in[capcmp2_bit];
    end
    if (write_hit(reset_cause_off)) begin
      state_next.power_on_n = wdata_in[power_on_bit];
      state_next.brownout_n = wdata_in[brownout_bit];
    end
    if (read_in) begin
      if (addr_in == flags1_off) begin
        state_next.rdata = flags1_hi_out;
      end else if (addr_in == flags2_off) begin
        state_next.rdata = {7'h00, capcmp2_irq_flag};
      end else if (addr_in == enable2_off) begin
        state_next.rdata = {7'h00, state_reg.capcmp2_enable};
      end else if (addr_in == reset_cause_off) begin
        // brown-out bit meaningless when detection is off
        state_next.rdata = {6'h00, state_reg.power_on_n, state_reg.brownout_n};
      end else begin
        state_next.rdata = 8'h00;
      end
    end
  end

  // reset loads constants only; the cause levels are sampled after release
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '{capcmp2_enable: enable2_reset[capcmp2_bit], power_on_n: 1'b1,
                     brownout_n: 1'b1, cause_pending: 1'b1, rdata: 8'h00};
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    flags1_hi_out = 8'h00;
    flags1_hi_out[timer1_overflow_bit] = timer1_overflow_flag;
    flags1_hi_out[timer2_match_bit] = timer2_match_flag;
    flags1_hi_out[parallel_port_bit] = 1'b0;
    flags1_hi_out[conversion_done_bit] = 1'b0;
    if (!has_parallel_port || !has_converter) begin
      flags1_hi_out[parallel_port_bit] = 1'b0;
    end
  end

  // enable gates only the request, never the flag
  assign capcmp2_request_out = capcmp2_irq_flag && state_reg.capcmp2_enable;
  assign rdata_out = state_reg.rdata;
endmodule : peripheral_irq_flags_reset_cause

// ===== sim/irq_flags_checker.sv
// assertions on the flag block ports
// assumes binding onto the flag block
`timescale 1ns/1ns
module irq_flags_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port and events
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] timer2_count_in,
  input wire logic [7:0] timer2_period_in,
  input wire logic timer2_tick_in,
  input wire logic [15:0] timer1_count_in,
  input wire logic timer1_tick_in,
  input wire irq_flags_pkg::capcmp_mode_e capcmp2_mode_in,
  input wire logic capcmp2_capture_in,
  input wire logic capcmp2_match_in,
  input wire logic [7:0] flags1_hi_out,
  input wire logic capcmp2_request_out
);
  import irq_flags_pkg::*;
  logic w1;
  assign w1 = write_in && addr_in == flags1_off;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_T2: assert property (timer2_tick_in && timer2_count_in == timer2_period_in |=> flags1_hi_out[1])
    else $error("match flag not set");
  AST_CLR: assert property (w1 && !wdata_in[1] && !timer2_tick_in |=> !flags1_hi_out[1])
    else $error("match flag not cleared");
  AST_T1: assert property (timer1_tick_in && timer1_count_in == 16'hffff |=> flags1_hi_out[0])
    else $error("overflow flag not set");
  AST_HOLD: assert property (!w1 |=> &(flags1_hi_out[1:0] | ~$past(flags1_hi_out[1:0])))
    else $error("flag dropped without write");
  AST_RSVD: assert property (flags1_hi_out[7:2] == 6'h00)
    else $error("reserved flag bits set");
  AST_RD2: assert property (read_in && addr_in[6:0] == 7'h0d |=> rdata_out[7:1] == 7'h00)
    else $error("unimplemented bits read nonzero");
  AST_REQ: assert property (write_in && addr_in == enable2_off && !wdata_in[0] |=> !capcmp2_request_out)
    else $error("request while disabled");
  AST_ROSE: assert property ($rose(capcmp2_request_out) |-> $past(capcmp2_capture_in || capcmp2_match_in || write_in))
    else $error("request without cause");
  AST_PWM: assert property ($rose(capcmp2_request_out) && !$past(write_in) |-> $past(capcmp2_mode_in) != capcmp_pwm)
    else $error("flag set in pwm mode");
  cover property (capcmp2_request_out);
  cover property (w1 && timer2_tick_in);
  cover property ($rose(flags1_hi_out[0]));
endmodule : irq_flags_checker
bind peripheral_irq_flags_reset_cause irq_flags_checker chk_u (.*);

// ===== sim/peripheral_irq_flags_reset_cause_test.sv
// register-level test of the flag block
// assumes the checker is bound in
`timescale 1ns/1ns
module peripheral_irq_flags_reset_cause_test;
  import irq_flags_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, write_in = 1'b0, read_in = 1'b0, req;
  logic t2 = 1'b0, t1 = 1'b0, cap = 1'b0, mat = 1'b0, por = 1'b1, bor = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, c2 = 8'h00, rdata_out, flags1_hi_out;
  logic [15:0] c1 = 16'h0000;
  capcmp_mode_e mode = capcmp_capture;
  int mismatches = 0, checks = 0, cyc = 0;
  always #50 clk_in = ~clk_in;
  peripheral_irq_flags_reset_cause dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .power_on_reset_in(por), .brownout_reset_in(bor), .brownout_detect_enable_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
    .rdata_out(rdata_out), .timer2_count_in(c2), .timer2_period_in(8'h40),
    .timer2_tick_in(t2), .timer1_count_in(c1), .timer1_tick_in(t1), .capcmp2_mode_in(mode),
    .capcmp2_capture_in(cap), .capcmp2_match_in(mat), .flags1_hi_out(flags1_hi_out),
    .capcmp2_request_out(req));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clk_in);
    write_in <= 1'b0;
    @(negedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clk_in);
    read_in <= 1'b0;
    @(negedge clk_in);
    chk("rdata", e, rdata_out);
  endtask : rd
  // event pulse: {timer2, timer1, capture, match}
  task automatic ev(input logic [3:0] m, input logic [7:0] a, input logic [15:0] b);
    @(posedge clk_in);
    {t2, t1, cap, mat} <= m;
    c2 <= a;
    c1 <= b;
    @(posedge clk_in);
    {t2, t1, cap, mat} <= 4'h0;
    @(negedge clk_in);
  endtask : ev
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(reset_cause_off, 8'h01);
    por <= 1'b0;
    rd(flags1_off, 8'h00);
    rd(flags2_off, 8'h00);
    rd(enable2_off, 8'h00);
    wr(reset_cause_off, 8'h03);
    rd(reset_cause_off, 8'h03);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    ev(4'hc, 8'h3f, 16'hfffe);
    chk("flags1", 8'h00, flags1_hi_out);
    ev(4'h8, 8'h40, 16'h0000);
    chk("flags1", 8'h02, flags1_hi_out);
    ev(4'h4, 8'h00, 16'hffff);
    chk("flags1", 8'h03, flags1_hi_out);
    wr(flags1_off, 8'h00);
    chk("flags1", 8'h00, flags1_hi_out);
    fork
      wr(flags1_off, 8'h00);
      ev(4'h8, 8'h40, 16'h0000);
    join
    chk("flags1", 8'h02, flags1_hi_out);
    ev(4'h2, 8'h00, 16'h0000);
    rd(flags2_off, 8'h01);
    chk("req", 8'h00, {7'h00, req});
    wr(flags2_off, 8'h00);
    wr(enable2_off, 8'hff);
    rd(enable2_off, 8'h01);
    chk("req", 8'h00, {7'h00, req});
    ev(4'h2, 8'h00, 16'h0000);
    chk("req", 8'h01, {7'h00, req});
    wr(flags2_off, 8'h00);
    mode <= capcmp_compare;
    ev(4'h1, 8'h00, 16'h0000);
    rd(flags2_off, 8'h01);
    wr(flags2_off, 8'h00);
    mode <= capcmp_pwm;
    ev(4'h3, 8'h00, 16'h0000);
    rd(flags2_off, 8'h00);
    wr(enable2_off, 8'h00);
    wr(flags2_off, 8'hff);
    rd(flags2_off, 8'h01);
    wr(reset_cause_off, 8'h00);
    rd(reset_cause_off, 8'h00);
    wr(reset_cause_off, 8'hff);
    rd(reset_cause_off, 8'h03);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    bor <= 1'b1;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(reset_cause_off, 8'h02);
    bor <= 1'b0;
    rd(flags1_off, 8'h00);
    conclude();
  end
endmodule : peripheral_irq_flags_reset_cause_test
